/* File: logic/rpu_params.svh */
`ifndef RPU_PARAMS_SVH
`define RPU_PARAMS_SVH

// ****************************************************************
// Coprocessor register numbers
// ****************************************************************
`define REG_CTRL        4'h1
`define REG_CACHABLE    4'h2
`define REG_BUFFERABLE  4'h3
`define REG_PERMISSION  4'h5
`define REG_REGION      4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_PROT_EN_BIT 0
`define SEL_DATA         3'h0
`define SEL_INSTR        3'h1
`define RGN_BASE_MSB     31
`define RGN_BASE_LSB     12
`define RGN_SIZE_MSB     5
`define RGN_SIZE_LSB     1
`define RGN_EN_BIT       0

// ****************************************************************
// Reset values and size coding
// ****************************************************************
`define CTRL_RESET       32'h0000_0000
`define ATTR_RESET       8'h00
`define PERM_RESET       16'h0000
`define BASE_RESET       20'h0_0000
`define SIZE_RESET       5'h00
`define SIZE_CODE_4KB    5'h0B
`define SIZE_CODE_4GB    5'h1F
`define NUM_REGIONS      8

`endif

/* File: logic/rpu_pkg.sv */
package rpu_pkg;

    // Access permission codes of a region
    typedef enum logic [1:0] {
        AP_NONE,
        AP_PRIV_ONLY,
        AP_USER_READ,
        AP_FULL
    } perm_t;

    typedef logic [19:0] base_t;
    typedef logic [4:0]  size_code_t;
    typedef logic [2:0]  region_idx_t;

endpackage : rpu_pkg

/* File: logic/region_protection_unit.sv */
// Overview of operation
// - Control register bit 0 enables protection
// - Protection off: everything noncachable, nonbufferable
// - Eight instruction regions, eight data regions
// - Region word: base, unused, size, enable
// - Reset clears every region enable
// - Size code 0B is 4KB, doubling upward
// - Cachable and permissions per region, bufferable data
// - Data cachable and bufferable select four behaviours
// - Failed permission check signals memory abort
// - Code 10 user read-only, 01 privileged only
// - Highest numbered matching region wins
// - Address in no enabled region aborts
// - Region 0 at 4GB acts as background
// - Configuration through coprocessor registers 1,2,3,5,6

`include "rpu_params.svh"

module region_protection_unit
    import rpu_pkg::*;
(
    input  wire logic        clock,        // Core clock
    input  wire logic        reset,        // Synchronous reset, high
    input  wire logic        cp_write,     // Coprocessor write strobe
    input  wire logic        cp_read,      // Coprocessor read strobe
    input  wire logic [3:0]  cp_reg,       // Register number
    input  wire logic [2:0]  cp_crm,       // Region number for reg 6
    input  wire logic [2:0]  cp_opc2,      // 0 data, 1 instruction
    input  wire logic [31:0] cp_wdata,     // Write data
    output logic      [31:0] cp_rdata,     // Read data, one cycle later
    input  wire logic        i_req,        // Instruction fetch valid
    input  wire logic [31:0] i_addr,       // Instruction address
    input  wire logic        i_priv,       // Fetch is privileged
    output logic             i_abort,      // Prefetch abort
    output logic             i_cachable,   // Fetch may be cached
    input  wire logic        d_req,        // Data access valid
    input  wire logic [31:0] d_addr,       // Data address
    input  wire logic        d_write,      // Data access is a store
    input  wire logic        d_priv,       // Data access is privileged
    output logic             d_abort,      // Data abort
    output logic             d_cachable,   // Data may be cached
    output logic             d_bufferable  // Data may be buffered
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Address bits 31:12 taking part in the compare for a size code
    function automatic base_t size_mask(input size_code_t code);
        base_t m;
        m = '0;
        for (int j = 0; j < 20; j++) begin
            m[j] = (5'(j + 12) > code);
        end
        return m;
    endfunction : size_mask

    // Highest set bit of a match vector
    function automatic region_idx_t top_index(input logic [7:0] v);
        region_idx_t idx;
        idx = '0;
        for (int k = 0; k < `NUM_REGIONS; k++) begin
            if (v[k]) begin
                idx = region_idx_t'(k);
            end
        end
        return idx;
    endfunction : top_index

    // Permission check of one access
    function automatic logic allowed(input logic [1:0] ap,
                                     input logic       priv,
                                     input logic       wr);
        logic ok;
        ok = 1'b0;
        unique case (perm_t'(ap))
            AP_NONE:      ok = 1'b0;
            AP_PRIV_ONLY: ok = priv;
            AP_USER_READ: ok = priv || !wr;
            AP_FULL:      ok = 1'b1;
        endcase
        return ok;
    endfunction : allowed

    // ****************************************************************
    // Configuration storage
    // ****************************************************************
    logic [31:0] ctrl;                         // Register 1
    logic [7:0]  i_cach;                       // Register 2, instruction
    logic [7:0]  d_cach;                       // Register 2, data
    logic [7:0]  d_buff;                       // Register 3, data only
    logic [15:0] i_perm;                       // Register 5, instruction
    logic [15:0] d_perm;                       // Register 5, data
    base_t       i_base [`NUM_REGIONS];
    base_t       d_base [`NUM_REGIONS];
    size_code_t  i_size [`NUM_REGIONS];
    size_code_t  d_size [`NUM_REGIONS];
    logic [7:0]  i_en;
    logic [7:0]  d_en;

    // Write decode
    wire sel_data   = (cp_opc2 == `SEL_DATA);
    wire sel_instr  = (cp_opc2 == `SEL_INSTR);
    wire wr_ctrl    = cp_write && (cp_reg == `REG_CTRL);
    wire wr_cach    = cp_write && (cp_reg == `REG_CACHABLE);
    wire wr_buff    = cp_write && (cp_reg == `REG_BUFFERABLE);
    wire wr_perm    = cp_write && (cp_reg == `REG_PERMISSION);
    wire wr_region  = cp_write && (cp_reg == `REG_REGION);
    wire prot_en    = ctrl[`CTRL_PROT_EN_BIT];

    // Control and attribute registers
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl   <= `CTRL_RESET;
            i_cach <= `ATTR_RESET;
            d_cach <= `ATTR_RESET;
            d_buff <= `ATTR_RESET;
            i_perm <= `PERM_RESET;
            d_perm <= `PERM_RESET;
        end else begin
            if (wr_ctrl)              ctrl   <= cp_wdata;
            if (wr_cach && sel_data)  d_cach <= cp_wdata[7:0];
            if (wr_cach && sel_instr) i_cach <= cp_wdata[7:0];
            if (wr_buff && sel_data)  d_buff <= cp_wdata[7:0];
            if (wr_perm && sel_data)  d_perm <= cp_wdata[15:0];
            if (wr_perm && sel_instr) i_perm <= cp_wdata[15:0];
        end
    end

    // ****************************************************************
    // Region registers and address matching
    // ****************************************************************
    logic [7:0] i_hit_vec;
    logic [7:0] d_hit_vec;

    for (genvar g = 0; g < `NUM_REGIONS; g++) begin : g_region
        wire   hit_slot = wr_region && (cp_crm == 3'(g));
        base_t i_mask;
        base_t d_mask;

        // Base, size and enable of one region in each space
        always_ff @(posedge clock) begin
            if (reset) begin
                i_en[g]   <= 1'b0;
                d_en[g]   <= 1'b0;
                i_base[g] <= `BASE_RESET;
                d_base[g] <= `BASE_RESET;
                i_size[g] <= `SIZE_RESET;
                d_size[g] <= `SIZE_RESET;
            end else begin
                if (hit_slot && sel_instr) begin
                    i_base[g] <= cp_wdata[`RGN_BASE_MSB:`RGN_BASE_LSB];
                    i_size[g] <= cp_wdata[`RGN_SIZE_MSB:`RGN_SIZE_LSB];
                    i_en[g]   <= cp_wdata[`RGN_EN_BIT];
                end
                if (hit_slot && sel_data) begin
                    d_base[g] <= cp_wdata[`RGN_BASE_MSB:`RGN_BASE_LSB];
                    d_size[g] <= cp_wdata[`RGN_SIZE_MSB:`RGN_SIZE_LSB];
                    d_en[g]   <= cp_wdata[`RGN_EN_BIT];
                end
            end
        end

        // A 4GB size masks every bit, so region 0 then matches all
        assign i_mask       = size_mask(i_size[g]);
        assign d_mask       = size_mask(d_size[g]);
        assign i_hit_vec[g] = i_en[g] &&
            (((i_addr[31:12] ^ i_base[g]) & i_mask) == '0);
        assign d_hit_vec[g] = d_en[g] &&
            (((d_addr[31:12] ^ d_base[g]) & d_mask) == '0);
    end

    // ****************************************************************
    // Priority, permission and attributes, same cycle
    // ****************************************************************
    wire region_idx_t i_win   = top_index(i_hit_vec);
    wire region_idx_t d_win   = top_index(d_hit_vec);
    wire              i_hit   = |i_hit_vec;
    wire              d_hit   = |d_hit_vec;
    wire logic [1:0]  i_ap    = i_perm[{i_win, 1'b0} +: 2];
    wire logic [1:0]  d_ap    = d_perm[{d_win, 1'b0} +: 2];
    wire              i_ok    = allowed(i_ap, i_priv, 1'b0);
    wire              d_ok    = allowed(d_ap, d_priv, d_write);

    // Abort on no match or failed check; attributes only when on
    assign i_abort      = i_req && prot_en && !(i_hit && i_ok);
    assign d_abort      = d_req && prot_en && !(d_hit && d_ok);
    assign i_cachable   = prot_en && i_hit && i_cach[i_win];
    assign d_cachable   = prot_en && d_hit && d_cach[d_win];
    assign d_bufferable = prot_en && d_hit && d_buff[d_win];

    // ****************************************************************
    // Register read back
    // ****************************************************************
    wire [31:0] rgn_word_i = {i_base[cp_crm], 6'h00, i_size[cp_crm],
                              i_en[cp_crm]};
    wire [31:0] rgn_word_d = {d_base[cp_crm], 6'h00, d_size[cp_crm],
                              d_en[cp_crm]};
    wire [31:0] read_mux =
        (cp_reg == `REG_CTRL)       ? ctrl :
        (cp_reg == `REG_CACHABLE)   ? {24'h00_0000,
                                       sel_instr ? i_cach : d_cach} :
        (cp_reg == `REG_BUFFERABLE) ? {24'h00_0000, d_buff} :
        (cp_reg == `REG_PERMISSION) ? {16'h0000,
                                       sel_instr ? i_perm : d_perm} :
        (cp_reg == `REG_REGION)     ? (sel_instr ? rgn_word_i
                                                 : rgn_word_d) :
                                      32'h0000_0000;

    // Read data register
    always_ff @(posedge clock) begin
        if (reset) begin
            cp_rdata <= 32'h0000_0000;
        end else if (cp_read) begin
            cp_rdata <= read_mux;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_ctrl_write;
        wr_ctrl;
    endsequence

    sequence s_d_user_store;
        d_req && prot_en && d_hit && !d_priv && d_write;
    endsequence

    // Data region write followed by one cycle with no register write
    sequence s_region_write;
        wr_region && sel_data ##1 !cp_write;
    endsequence

    property p_ctrl_enable;
        s_ctrl_write |=> prot_en == $past(cp_wdata[`CTRL_PROT_EN_BIT]);
    endproperty
    a_ctrl_enable: assert property (p_ctrl_enable)
        else $error("protection enable does not follow control write");

    property p_ctrl_hold;
        !wr_ctrl |=> $stable(prot_en);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("protection enable changed without control write");

    property p_off_attrs;
        !prot_en |-> !i_cachable && !d_cachable && !d_bufferable
                     && !i_abort && !d_abort;
    endproperty
    a_off_attrs: assert property (p_off_attrs)
        else $error("attributes or abort while protection off");

    property p_reset_clears;
        $past(reset) |-> (i_en == 8'h00) && (d_en == 8'h00);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("region enabled after reset");

    property p_user_read_only;
        s_d_user_store ##0 (d_ap == 2'b10) |-> d_abort;
    endproperty
    a_user_read_only: assert property (p_user_read_only)
        else $error("user store to read-only region not aborted");

    property p_priv_only;
        d_req && prot_en && d_hit && !d_priv && d_ap == 2'b01
            |-> d_abort;
    endproperty
    a_priv_only: assert property (p_priv_only)
        else $error("user access to privileged region not aborted");

    property p_no_match;
        i_req && prot_en && (i_hit_vec == 8'h00) |-> i_abort;
    endproperty
    a_no_match: assert property (p_no_match)
        else $error("fetch outside all regions not aborted");

    property p_top_wins;
        d_hit_vec[7] |-> (d_win == 3'h7);
    endproperty
    a_top_wins: assert property (p_top_wins)
        else $error("region 7 match did not take priority");

    property p_attr_select;
        prot_en && d_hit |->
            d_cachable == d_cach[d_win] && d_bufferable == d_buff[d_win];
    endproperty
    a_attr_select: assert property (p_attr_select)
        else $error("data attributes not from winning region");

    property p_background;
        d_en[0] && d_size[0] == 5'h1F |-> d_hit_vec[0];
    endproperty
    a_background: assert property (p_background)
        else $error("4GB region 0 failed to match");

    property p_region_readback;
        s_region_write ##1 (cp_read && cp_reg == `REG_REGION && sel_data
            && cp_crm == $past(cp_crm, 2) && !cp_write)
            |=> cp_rdata == ($past(cp_wdata, 3) & 32'hFFFF_F03F);
    endproperty
    a_region_readback: assert property (p_region_readback)
        else $error("region word read back differs from write");

endmodule : region_protection_unit

/* File: dv/core_model.sv */
module core_model (
    input  wire logic        clock,   // Core clock
    output logic             i_req,   // Fetch valid
    output logic      [31:0] i_addr,  // Fetch address
    output logic             i_priv,  // Fetch privileged
    output logic             d_req,   // Data access valid
    output logic      [31:0] d_addr,  // Data address
    output logic             d_write, // Data store
    output logic             d_priv   // Data privileged
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        i_req   = 1'b0;
        i_addr  = 32'h0000_0000;
        i_priv  = 1'b0;
        d_req   = 1'b0;
        d_addr  = 32'h0000_0000;
        d_write = 1'b0;
        d_priv  = 1'b0;
    end

    // *****
    // One-cycle accesses; released lines scrambled
    // *****
    task automatic fetch(input logic [31:0] a, input logic p);
        @(posedge clock);
        i_req  <= 1'b1;
        i_addr <= a;
        i_priv <= p;
        @(posedge clock);
        i_req  <= 1'b0;
        i_addr <= ~a;
        i_priv <= ~p;
    endtask : fetch

    // Data access, separate from fetches so aborts stay apart
    task automatic data(input logic [31:0] a, input logic p, w);
        @(posedge clock);
        d_req   <= 1'b1;
        d_addr  <= a;
        d_priv  <= p;
        d_write <= w;
        @(posedge clock);
        d_req   <= 1'b0;
        d_addr  <= ~a;
        d_priv  <= ~p;
        d_write <= ~w;
    endtask : data
endmodule : core_model

/* File: dv/region_protection_unit_tb.sv */
`include "rpu_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    mismatches++; $display("Error %s expected %h seen %h", nm, e, g); \
    end end

module region_protection_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock = 1'b0;
    logic        rd_d = 1'b0;
    logic        reset, cp_write, cp_read;
    logic [3:0]  cp_reg;
    logic [2:0]  cp_crm, cp_opc2, got3;
    logic [31:0] cp_wdata, cp_rdata, i_addr, d_addr, v, sz, ex32;
    logic        i_req, i_priv, i_abort, i_cachable, ab, wab;
    logic        d_req, d_write, d_priv, d_abort, d_cachable, d_bufferable;
    logic [1:0]  got2;
    logic [31:0] rq[$];
    logic [5:0]  dq[$], e6;
    logic [3:0]  iq[$], e4;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          seed;

    always #5 clock = ~clock;

    region_protection_unit DUT (.clock(clock), .reset(reset),
        .cp_write(cp_write), .cp_read(cp_read), .cp_reg(cp_reg),
        .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata),
        .cp_rdata(cp_rdata), .i_req(i_req), .i_addr(i_addr),
        .i_priv(i_priv), .i_abort(i_abort), .i_cachable(i_cachable),
        .d_req(d_req), .d_addr(d_addr), .d_write(d_write),
        .d_priv(d_priv), .d_abort(d_abort), .d_cachable(d_cachable),
        .d_bufferable(d_bufferable));

    core_model core (.clock(clock), .i_req(i_req), .i_addr(i_addr),
        .i_priv(i_priv), .d_req(d_req), .d_addr(d_addr),
        .d_write(d_write), .d_priv(d_priv));

    // *****
    // Bus tasks; rd, dacc and facc note their expectation, set does not
    // *****
    task automatic set(input logic [3:0] r, input logic [2:0] n, s,
                       input logic [31:0] val);
        @(posedge clock);
        cp_write <= 1'b1;
        cp_reg   <= r;
        cp_crm   <= n;
        cp_opc2  <= s;
        cp_wdata <= val;
        @(posedge clock);
        cp_write <= 1'b0;
        cp_wdata <= ~val;
    endtask : set

    task automatic rd(input logic [3:0] r, input logic [2:0] n, s,
                      input logic [31:0] e);
        rq.push_back(e);
        @(posedge clock);
        cp_read <= 1'b1;
        cp_reg  <= r;
        cp_crm  <= n;
        cp_opc2 <= s;
        @(posedge clock);
        cp_read <= 1'b0;
    endtask : rd

    // Data expectation is {mask, abort, cachable, bufferable}
    task automatic dacc(input logic [31:0] a, input logic p, w,
                        input logic [5:0] e);
        dq.push_back(e);
        core.data(a, p, w);
    endtask : dacc

    task automatic facc(input logic [31:0] a, input logic p,
                        input logic [3:0] e);
        iq.push_back(e);
        core.fetch(a, p);
    endtask : facc

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // Monitor: results compared where they appear, plus hang guard
    always @(posedge clock) begin
        cyc  <= cyc + 1;
        rd_d <= cp_read;
        if (rd_d) begin
            ex32 = rq.pop_front();
            `CHK("cp_rdata", ex32, cp_rdata)
        end
        if (d_req) begin
            e6   = dq.pop_front();
            got3 = {d_abort, d_cachable, d_bufferable} & e6[5:3];
            `CHK("data", e6[2:0], got3)
        end
        if (i_req) begin
            e4   = iq.pop_front();
            got2 = {i_abort, i_cachable} & e4[3:2];
            `CHK("fetch", e4[1:0], got2)
        end
        if (cyc == 6000) begin
            mismatches++;
            wrap_up();
        end
    end

    // *****
    // Main sequence
    // *****
    initial begin
        reset    = 1'b1;
        cp_write = 1'b0;
        cp_read  = 1'b0;
        cp_reg   = 4'h0;
        cp_crm   = 3'h0;
        cp_opc2  = 3'h0;
        cp_wdata = 32'h0000_0000;
        seed = $urandom(10138);
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        for (int n = 0; n < 16; n++)
            rd(`REG_REGION, n[2:0], {2'b00, n[3]}, 32'h0);
        set(`REG_CACHABLE, 0, 0, 32'hFF);
        set(`REG_BUFFERABLE, 0, 0, 32'hFF);
        dacc(32'h3010, 0, 1, 6'h38);
        facc(32'h3010, 0, 4'hC);
        $display("test reset done");
        for (int n = 0; n < 16; n++) begin
            v = $urandom();
            set(`REG_REGION, n[2:0], {2'b00, n[3]}, v);
            rd(`REG_REGION, n[2:0], {2'b00, n[3]}, v & 32'hFFFF_F03F);
            set(`REG_REGION, n[2:0], {2'b00, n[3]}, 32'h0);
        end
        set(4'h4, 0, 0, 32'hFFFF_FFFF);
        rd(4'h4, 0, 0, 32'h0);
        $display("test registers done");
        set(`REG_REGION, 2, 0, 32'h0000_3017);
        set(`REG_REGION, 1, 0, 32'h0000_001B);
        set(`REG_PERMISSION, 0, 0, 32'h24);
        set(`REG_CACHABLE, 0, 0, 32'h04);
        set(`REG_BUFFERABLE, 0, 0, 32'h02);
        set(`REG_REGION, 0, 1, 32'h0000_003F);
        set(`REG_PERMISSION, 0, 1, 32'h03);
        set(`REG_CACHABLE, 0, 1, 32'h01);
        set(`REG_CTRL, 0, 0, 32'h1);
        rd(`REG_CTRL, 0, 0, 32'h1);
        dacc(32'h3010, 0, 0, 6'h3A);
        dacc(32'h3010, 0, 1, 6'h24);
        dacc(32'h1000, 0, 0, 6'h24);
        dacc(32'h1000, 1, 1, 6'h39);
        dacc(32'h8000, 1, 0, 6'h3C);
        facc(32'h8000, 0, 4'hD);
        set(`REG_REGION, 0, 0, 32'h0000_003F);
        set(`REG_PERMISSION, 0, 0, 32'h27);
        dacc(32'h8000, 0, 1, 6'h38);
        $display("test overlap done");
        for (int k = 0; k < 4; k++) begin
            set(`REG_CACHABLE, 0, 0, {29'h0, k[1], 2'b00});
            set(`REG_BUFFERABLE, 0, 0, {29'h0, k[0], 2'b00});
            dacc(32'h3FFC, 1, 0, {4'hE, k[1:0]});
        end
        $display("test attributes done");
        for (int a = 0; a < 8; a++) begin
            ab = (a[2:1] == 0) || (a[2:1] == 1 && !a[0]);
            wab = ab || (a[2:1] == 2 && !a[0]);
            set(`REG_PERMISSION, 0, 0, {26'h0, a[2:1], 4'h7});
            set(`REG_PERMISSION, 0, 1, {30'h0, a[2:1]});
            dacc(32'h3010, a[0], 1'b0, {3'h4, ab, 2'h0});
            dacc(32'h3010, a[0], 1'b1, {3'h4, wab, 2'h0});
            facc(32'h3010, a[0], {2'h2, ab, 1'b0});
        end
        $display("test permissions done");
        set(`REG_REGION, 0, 1, 32'h0);
        set(`REG_PERMISSION, 0, 1, 32'hC0);
        set(`REG_CACHABLE, 0, 1, 32'h08);
        for (int c = 11; c < 30; c++) begin
            sz = 32'h1 << (c + 1);
            set(`REG_REGION, 3, 1, sz | (c << 1) | 1);
            facc(sz - 1, 0, 4'hE);
            facc(sz + ($urandom() % sz), 0, 4'hD);
            facc(sz + sz - 1, 0, 4'hD);
            facc(sz + sz, 0, 4'hE);
        end
        set(`REG_REGION, 3, 1, 32'h0000_003F);
        facc($urandom(), 0, 4'hD);
        $display("test sizes done");
        set(`REG_CACHABLE, 0, 0, 32'hFF);
        set(`REG_CTRL, 0, 0, 32'h0);
        dacc(32'h3010, 0, 1, 6'h38);
        facc(32'h8000, 0, 4'hC);
        $display("test disable done");
        repeat (3) @(posedge clock);
        wrap_up();
    end
endmodule : region_protection_unit_tb
